// file: timer_pkg.sv
package timer_pkg;
	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFS_COUNT = 8'h00;
	localparam logic [7:0] OFS_PERIOD = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_ENABLES = 8'h10;

	// Values after reset
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'hff;
	localparam logic [6:0] CONTROL_RST = 7'h00;

	// Control field positions
	localparam int PRESCALE_LSB = 0;
	localparam int TIMER_ON_BIT = 2;
	localparam int POSTSCALE_LSB = 3;
	localparam int POSTSCALE_W = 4;
	localparam int CONTROL_W = 7;

	// Flag and enable bit position
	localparam int MATCH_BIT = 1;

	// Instruction clock divider and prescaler terminal counts, match pulse length in core clocks
	localparam logic [3:0] INSTR_DIV_LAST = 4'h3;
	localparam logic [3:0] PRESCALE_LAST_1 = 4'h0;
	localparam logic [3:0] PRESCALE_LAST_4 = 4'h3;
	localparam logic [3:0] PRESCALE_LAST_16 = 4'hf;
	localparam int MATCH_PULSE_CYCLES = 4;
endpackage

// file: tick_divider.sv
`timescale 1ns/1ps
module tick_divider #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic clear_i,
	input wire logic step_i,
	input wire logic [WIDTH-1:0] last_i,
	// Status
	output logic done_o,
	output logic [WIDTH-1:0] cnt_o
);
	logic [WIDTH-1:0] cnt_reg;

	// Terminal step of the ratio
	assign done_o = step_i && !clear_i && (cnt_reg >= last_i);
	assign cnt_o = cnt_reg;

	// Counter holds between steps, wraps at the terminal count
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= '0;
		end else if (clear_i) begin
			cnt_reg <= '0;
		end else if (step_i) begin
			cnt_reg <= (cnt_reg >= last_i) ? '0 : cnt_reg + 1'b1;
		end
	end
endmodule

// file: period_timer.sv
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module period_timer (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [timer_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [timer_pkg::DATA_W-1:0] pwdata_i,
	output logic [timer_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Match outputs
	output logic pwm_time_base_o,
	output logic serial_shift_clk_o,
	output logic gate_pulse_o,
	// Interrupt request
	output logic match_irq_o
);
	import timer_pkg::*;

	logic [7:0] timer_count_reg;
	logic [7:0] period_value_reg;
	logic [CONTROL_W-1:0] timer_control_reg;
	logic match_irq_flag_reg;
	logic match_irq_enable_reg;
	logic match_pulse_reg;
	logic ack_reg;
	logic [DATA_W-1:0] prdata_reg;
	logic slverr_reg;

	logic access;
	logic wr_commit;
	logic addr_hit;
	logic count_wr;
	logic period_wr;
	logic control_wr;
	logic flags_wr;
	logic enables_wr;
	logic scaler_clr;
	logic timer_on;
	logic [1:0] prescale_select;
	logic [3:0] prescale_last;
	logic [POSTSCALE_W-1:0] postscale_select;
	logic instr_tick;
	logic inc_event;
	logic count_equal;
	logic match_event;
	logic post_done;
	logic [3:0] pre_cnt;
	logic [POSTSCALE_W-1:0] post_cnt;
	logic [DATA_W-1:0] rd_value;

	// Bus decode; writes act only at the edge where pready is high
	assign access = psel_i && penable_i;
	assign pready_o = access && ack_reg;
	assign wr_commit = pready_o && pwrite_i && !slverr_reg;
	assign count_wr = wr_commit && (paddr_i == OFS_COUNT);
	assign period_wr = wr_commit && (paddr_i == OFS_PERIOD);
	assign control_wr = wr_commit && (paddr_i == OFS_CONTROL);
	assign flags_wr = wr_commit && (paddr_i == OFS_FLAGS);
	assign enables_wr = wr_commit && (paddr_i == OFS_ENABLES);
	assign addr_hit = (paddr_i == OFS_COUNT) || (paddr_i == OFS_PERIOD) ||
		(paddr_i == OFS_CONTROL) || (paddr_i == OFS_FLAGS) || (paddr_i == OFS_ENABLES);
	assign prdata_o = prdata_reg;
	assign pslverr_o = pready_o && slverr_reg;

	// Control fields
	assign timer_on = timer_control_reg[TIMER_ON_BIT];
	assign prescale_select = timer_control_reg[PRESCALE_LSB +: 2];
	assign postscale_select = timer_control_reg[POSTSCALE_LSB +: POSTSCALE_W];
	assign scaler_clr = count_wr || control_wr;

	// Prescaler terminal count from the select field
	always_comb begin
		unique case (prescale_select)
			2'b00: prescale_last = PRESCALE_LAST_1;
			2'b01: prescale_last = PRESCALE_LAST_4;
			default: prescale_last = PRESCALE_LAST_16;
		endcase
	end

	// Read mux; unimplemented bits read as zero
	always_comb begin
		rd_value = '0;
		unique case (paddr_i)
			OFS_COUNT: rd_value[7:0] = timer_count_reg;
			OFS_PERIOD: rd_value[7:0] = period_value_reg;
			OFS_CONTROL: rd_value[CONTROL_W-1:0] = timer_control_reg;
			OFS_FLAGS: rd_value[MATCH_BIT] = match_irq_flag_reg;
			OFS_ENABLES: rd_value[MATCH_BIT] = match_irq_enable_reg;
			default: rd_value = '0;
		endcase
	end

	// One wait state: data and error captured, then pready
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_reg <= 1'b0;
			prdata_reg <= '0;
			slverr_reg <= 1'b0;
		end else if (access && !ack_reg) begin
			ack_reg <= 1'b1;
			prdata_reg <= pwrite_i ? '0 : rd_value;
			slverr_reg <= !addr_hit;
		end else begin
			ack_reg <= 1'b0;
		end
	end

	// Instruction clock: core clock divided by four, free running
	tick_divider #(.WIDTH(4)) instr_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(1'b0),
		.step_i(1'b1),
		.last_i(INSTR_DIV_LAST),
		.done_o(instr_tick),
		.cnt_o()
	);

	// Prescaler, stepped only while the timer is on
	tick_divider #(.WIDTH(4)) prescaler (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(scaler_clr),
		.step_i(instr_tick && timer_on),
		.last_i(prescale_last),
		.done_o(inc_event),
		.cnt_o(pre_cnt)
	);

	// Comparison every cycle; a match acts at the next increment
	assign count_equal = (timer_count_reg == period_value_reg);
	assign match_event = inc_event && count_equal;

	// Postscaler counts match events
	tick_divider #(.WIDTH(POSTSCALE_W)) postscaler (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(scaler_clr),
		.step_i(match_event),
		.last_i(postscale_select),
		.done_o(post_done),
		.cnt_o(post_cnt)
	);

	// Count register; a software write wins over an increment
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			timer_count_reg <= COUNT_RST;
		end else if (count_wr) begin
			timer_count_reg <= pwdata_i[7:0];
		end else if (match_event) begin
			timer_count_reg <= COUNT_RST;
		end else if (inc_event) begin
			timer_count_reg <= timer_count_reg + 8'h01;
		end
	end

	// Period register
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			period_value_reg <= PERIOD_RST;
		end else if (period_wr) begin
			period_value_reg <= pwdata_i[7:0];
		end
	end

	// Control register; bit 7 not stored
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			timer_control_reg <= CONTROL_RST;
		end else if (control_wr) begin
			timer_control_reg <= pwdata_i[CONTROL_W-1:0];
		end
	end

	// Match pulse lasts one instruction cycle, frozen while off
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			match_pulse_reg <= 1'b0;
		end else if (match_event) begin
			match_pulse_reg <= 1'b1;
		end else if (instr_tick && timer_on) begin
			match_pulse_reg <= 1'b0;
		end
	end

	// Sticky flag; a completion in the clearing cycle wins
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			match_irq_flag_reg <= 1'b0;
		end else if (post_done) begin
			match_irq_flag_reg <= 1'b1;
		end else if (flags_wr) begin
			match_irq_flag_reg <= pwdata_i[MATCH_BIT];
		end
	end

	// Interrupt enable
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			match_irq_enable_reg <= 1'b0;
		end else if (enables_wr) begin
			match_irq_enable_reg <= pwdata_i[MATCH_BIT];
		end
	end

	// Outputs
	assign pwm_time_base_o = match_pulse_reg;
	assign serial_shift_clk_o = match_pulse_reg;
	assign gate_pulse_o = match_pulse_reg;
	assign match_irq_o = match_irq_flag_reg && match_irq_enable_reg;

	// Checks
	a_match_reload: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(match_event && !count_wr) |=> (timer_count_reg == 8'h00))
		else $error("count not reloaded after match");
	a_count_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(inc_event && !count_equal && !count_wr) |=>
		(timer_count_reg == $past(timer_count_reg) + 8'h01))
		else $error("count did not step by one");
	a_off_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(!timer_on && !count_wr) |=> ($stable(timer_count_reg) && $stable(match_pulse_reg)))
		else $error("timer moved while off");
	a_ctrl_keeps_count: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(control_wr && !inc_event) |=> $stable(timer_count_reg))
		else $error("control write changed count");
	a_scaler_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(count_wr || control_wr) |=> (pre_cnt == 4'h0 && post_cnt == 4'h0))
		else $error("scalers not cleared by write");
	a_flag_latch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		post_done |=> match_irq_flag_reg)
		else $error("flag not set on postscaler completion");
	a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(match_irq_flag_reg && !flags_wr) |=> match_irq_flag_reg)
		else $error("flag dropped without software clear");
	a_pulse_width: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(match_pulse_reg) |-> match_pulse_reg[*4])
		else $error("match pulse shorter than one instruction cycle");
	a_irq_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(post_done && match_irq_enable_reg && !enables_wr) |=> match_irq_o)
		else $error("enabled interrupt not raised on completion");
	a_ctrl_bit7: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(access && !ack_reg && !pwrite_i && paddr_i == OFS_CONTROL) |=>
		(prdata_o[DATA_W-1:CONTROL_W] == '0))
		else $error("control upper bits read nonzero");
	a_prescale_4: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(inc_event && prescale_select == 2'b01) |-> (pre_cnt == 4'h3))
		else $error("prescaler 1:4 terminal wrong");
	a_pulse_rise: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		match_event |=> pwm_time_base_o)
		else $error("time base did not rise after match");
	a_pulse_fall: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(match_pulse_reg && instr_tick && timer_on && !match_event) |=> !match_pulse_reg)
		else $error("match pulse longer than one instruction cycle");
	a_prescale_1: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(inc_event && prescale_select == 2'b00) |-> (pre_cnt == 4'h0))
		else $error("prescaler 1:1 terminal wrong");
	a_prescale_16: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(inc_event && prescale_select[1]) |-> (pre_cnt == 4'hf))
		else $error("prescaler 1:16 terminal wrong");
	a_post_ratio: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		post_done |-> (post_cnt == postscale_select))
		else $error("postscaler completed at wrong count");
	a_flag_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(flags_wr && !pwdata_i[MATCH_BIT] && !post_done) |=> !match_irq_flag_reg)
		else $error("flag not cleared by software");
	a_count_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		count_wr |=> (timer_count_reg == 8'($past(pwdata_i))))
		else $error("count write did not land");
	a_period_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		period_wr |=> (period_value_reg == 8'($past(pwdata_i))))
		else $error("period write did not land");
	a_off_no_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!timer_on |-> !inc_event)
		else $error("count advanced while timer off");
	a_instr_rate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		instr_tick |=> (!instr_tick)[*3])
		else $error("instruction clock faster than one in four");
endmodule

// file: match_consumer.sv
`timescale 1ns/1ps
module match_consumer (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Match signals from the timer
	input wire logic pwm_time_base_i,
	input wire logic serial_shift_clk_i,
	input wire logic gate_pulse_i,
	// What the PWM unit and serial port saw
	output int pulses_o,
	output int interval_o,
	output int width_o,
	output logic agree_o
);
	logic last;
	int gap;
	int hi;

	// Time base user: counts rises, spacing and high time
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last <= 1'h0;
			gap <= 0;
			hi <= 0;
			pulses_o <= 0;
			interval_o <= 0;
			width_o <= 0;
			agree_o <= 1'h1;
		end else begin
			gap <= gap + 1;
			last <= pwm_time_base_i;
			if (pwm_time_base_i) hi <= hi + 1;
			if (pwm_time_base_i && !last) begin
				pulses_o <= pulses_o + 1;
				interval_o <= gap;
				gap <= 1;
				hi <= 1;
			end
			if (!pwm_time_base_i && last) width_o <= hi;
			// Shift clock and gate must follow the time base
			if (serial_shift_clk_i !== pwm_time_base_i || gate_pulse_i !== pwm_time_base_i) begin
				agree_o <= 1'h0;
			end
		end
	end
endmodule

// file: period_timer_tb.sv
`timescale 1ns/1ps
module period_timer_tb;
	import timer_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, pwm, ssc, gate, irq, agree, e;
	int pulses, iv, wd, p, k, n0;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;

	period_timer period_timer_inst (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pwm_time_base_o(pwm),
		.serial_shift_clk_o(ssc), .gate_pulse_o(gate), .match_irq_o(irq));
	match_consumer match_consumer_inst (.core_clk_i(clk), .rst_n_i(rst_n),
		.pwm_time_base_i(pwm), .serial_shift_clk_i(ssc), .gate_pulse_i(gate),
		.pulses_o(pulses), .interval_o(iv), .width_o(wd), .agree_o(agree));

	// Clock and hang guard
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			num_errors++;
			final_report;
		end
	end

	task final_report;
		$display("errors %0d of %0d checks", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task chk(input string s, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", s, x, g);
		end
	endtask

	// One APB transfer; result left in r and e
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		chk("pready", 32'h1, {31'h0, pready});
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask

	// Core clocks between matches
	function int ivl(int c, int per);
		return 4 * (c == 0 ? 1 : (c == 1 ? 4 : 16)) * (per + 1);
	endfunction

	task wait_pulses(input int n);
		n0 = pulses;
		for (int i = 0; i < 20000 && pulses < n0 + n; i++) @(posedge clk);
	endtask

	initial begin
		void'($urandom(32'h7b86));
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		// Reset values
		apb(1'h0, OFS_COUNT, 32'h0);
		chk("count rst", {24'h0, COUNT_RST}, r);
		apb(1'h0, OFS_PERIOD, 32'h0);
		chk("period rst", {24'h0, PERIOD_RST}, r);
		apb(1'h0, OFS_CONTROL, 32'h0);
		chk("control rst", 32'h0, r);
		// Stopped timer: writes act, control write keeps count
		for (int i = 0; i < 4; i++) begin
			p = $urandom;
			apb(1'h1, OFS_COUNT, p);
			apb(1'h1, OFS_PERIOD, ~p);
			apb(1'h1, OFS_CONTROL, p & 32'hfb);
			repeat (40) @(posedge clk);
			apb(1'h0, OFS_COUNT, 32'h0);
			chk("count held", p & 32'hff, r);
			apb(1'h0, OFS_PERIOD, 32'h0);
			chk("period", ~p & 32'hff, r);
			apb(1'h0, OFS_CONTROL, 32'h0);
			chk("control", p & 32'h7b, r);
		end
		// Unmapped address
		apb(1'h1, 8'h14, 32'hff);
		chk("unmapped err", 32'h1, {31'h0, e});
		apb(1'h0, 8'h14, 32'h0);
		chk("unmapped data", 32'h0, r);
		// Match spacing for every prescale code
		for (k = 0; k < 4; k++) begin
			p = 1 + $urandom % 8;
			apb(1'h1, OFS_PERIOD, p);
			apb(1'h1, OFS_COUNT, 32'h0);
			apb(1'h1, OFS_CONTROL, ($urandom & 32'h78) | 32'h4 | k);
			wait_pulses(3);
			chk("pulses", n0 + 3, pulses);
			chk("interval", ivl(k, p), iv);
			chk("pulse width", MATCH_PULSE_CYCLES, wd);
		end
		chk("outputs agree", 32'h1, {31'h0, agree});
		// Matches per flag for every postscale code
		apb(1'h1, OFS_ENABLES, 32'h2);
		for (k = 0; k < 16; k++) begin
			apb(1'h1, OFS_CONTROL, 32'h0);
			apb(1'h1, OFS_FLAGS, 32'h0);
			chk("irq cleared", 32'h0, {31'h0, irq});
			n0 = pulses;
			apb(1'h1, OFS_CONTROL, (k << 3) | 32'h4);
			for (int i = 0; i < 2000 && irq !== 1'h1; i++) @(posedge clk);
			repeat (2) @(posedge clk);
			chk("matches per flag", k + 1, pulses - n0);
		end
		// Masking, flag read back, software clear
		apb(1'h1, OFS_CONTROL, 32'h0);
		apb(1'h1, OFS_ENABLES, 32'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'h0, OFS_FLAGS, 32'h0);
		chk("flag latched", 32'h2, r);
		apb(1'h1, OFS_ENABLES, 32'h2);
		chk("irq enabled", 32'h1, {31'h0, irq});
		apb(1'h1, OFS_FLAGS, 32'h0);
		chk("irq after clear", 32'h0, {31'h0, irq});
		final_report;
	end
endmodule
